// file: rtl/rdi_cfg.svh
// constants for the release / depopulate / identifier command decoder
`ifndef RDI_CFG_SVH
`define RDI_CFG_SVH
// command codes and service actions
`define RDI_OP_RELEASE10 8'h57
`define RDI_OP_DEPOP 8'h9e
`define RDI_SA_DEPOP 5'h18
`define RDI_OP_RPTID 8'ha3
`define RDI_SA_RPTID 5'h05
// release byte 1 field positions
`define RDI_REL_TP_BIT 4
// element type code of a storage element
`define RDI_ELEM_STORAGE 8'h01
// status codes
`define RDI_ST_GOOD 8'h00
`define RDI_ST_CHECK 8'h02
// sense triplets: key, additional sense code, qualifier
`define RDI_SNS_NONE {4'h0, 8'h00, 8'h00}
`define RDI_SNS_INV_CDB {4'h5, 8'h24, 8'h00}
`define RDI_SNS_DEPOP_FAIL {4'h3, 8'h31, 8'h03}
`define RDI_SNS_UCODE_ACT {4'h2, 8'h04, 8'h11}
`define RDI_SNS_NV_NRDY {4'h2, 8'h04, 8'h00}
// sense key values used by checks
`define RDI_SK_ILLEGAL 4'h5
`define RDI_SK_NOT_READY 4'h2
`define RDI_SK_MEDIUM 4'h3
// capacity after reset, identifier storage size, length-field bytes
`define RDI_CAP_RESET 64'h0000_0000_0100_0000
`define RDI_ID_BYTES 16
`define RDI_LEN_BYTES 8'h04
`endif

// file: rtl/rdi_pkg.sv
// types for the release / depopulate / identifier command decoder
package rdi_pkg;
   typedef enum logic [1:0]
   {
      RDI_IDLE = 2'b00,
      RDI_WAIT = 2'b01,
      RDI_XFER = 2'b10
   } rdi_state_e;
   typedef logic [19:0] rdi_sense_t;
endpackage

// file: rtl/rdi_cmd_decoder.sv
// command decoder for release(10), element removal and identifier report
`timescale 1ns/1ps
`default_nettype none
`include "rdi_cfg.svh"

// Operation
// R1: opcode 57h releases a reservation previously taken.
// R2: release by a non-owner returns good, reservation kept.
// R3: nonzero third-party flag gives check, illegal request, invalid field.
// R4: initiator keeps the extent flag zero.
// R5: reservation identification byte is ignored.
// R6: opcode 9Eh, action 18h removes an element and shrinks capacity.
// R7: requested capacity is final block count; zero lets device choose.
// R8: capacity not settable: keep capacity, check, illegal, invalid field.
// R9: element not type 01h or unsupported: check, invalid field.
// R10: failed removal sets format-corrupt; only a clean format clears it (the decoder also clears it on i_nrst).
// R11: while corrupt, medium access gets check, medium error, depop failed.
// R12: deferred microcode pending: check, not ready, activation required.
// R13: element not removable: check, illegal request, invalid field.
// R14: opcode A3h, action 05h; nonzero unit field gives invalid field.
// R15: short allocation returns leading data without error.
// R16: data opens with 4-byte full identifier length, then identifier.
// R17: length starts zero, changes only on successful set-identifier.
// R18: identifier survives resets and formats.
// R19: one identifier for every initiator and port.
// R20: store not ready gives immediate check, not ready.
// R21: handler chosen from opcode and service action before checks.
module rdi_cmd_decoder
   import rdi_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_cdb_valid,
   input wire logic [127:0] i_cdb,
   input wire logic [7:0] i_initiator,
   input wire logic i_medium_access,
   input wire logic i_resv_take,
   input wire logic i_ucode_deferred,
   input wire logic [7:0] i_elem_type,
   input wire logic i_elem_known,
   input wire logic i_elem_depop_ok,
   input wire logic [63:0] i_cap_auto,
   input wire logic i_op_done,
   input wire logic i_op_fail,
   input wire logic i_format_ok,
   input wire logic i_nv_ready,
   input wire logic i_nv_init,
   input wire logic i_setid_valid,
   input wire logic [7:0] i_setid_len,
   input wire logic [127:0] i_setid_data,
   output logic o_busy,
   output logic o_done,
   output logic o_pass,
   output logic [7:0] o_status,
   output logic [3:0] o_sense_key,
   output logic [7:0] o_asc,
   output logic [7:0] o_ascq,
   output logic o_resv_active,
   output logic [7:0] o_resv_owner,
   output logic [63:0] o_capacity,
   output logic o_fmt_corrupt,
   output logic o_op_start,
   output logic [31:0] o_op_elem,
   output logic [63:0] o_op_cap,
   output logic o_din_valid,
   output logic [7:0] o_din_byte
);

   function automatic logic [7:0] cdb_byte(input logic [127:0] c,
                                           input int unsigned n);
      cdb_byte = c[127 - 8*n -: 8];
   endfunction

   // byte n of the parameter list: 4-byte length, then identifier
   function automatic logic [7:0] list_byte(input logic [7:0] n,
                                            input logic [7:0] len,
                                            input logic [127:0] id);
      logic [7:0] k;
      k = n - `RDI_LEN_BYTES;
      if (n < `RDI_LEN_BYTES)
         list_byte = (n == 8'h03) ? len : 8'h00;
      else
         list_byte = id[127 - 8*k[3:0] -: 8];
   endfunction

   rdi_state_e state;
   rdi_state_e next_state;
   rdi_sense_t sense;
   rdi_sense_t next_sense;
   logic busy, next_busy;
   logic done, next_done;
   logic pass, next_pass;
   logic [7:0] status, next_status;
   logic resv_active, next_resv_active;
   logic [7:0] resv_owner, next_resv_owner;
   logic [63:0] capacity, next_capacity;
   logic fmt_corrupt, next_fmt_corrupt;
   logic op_start, next_op_start;
   logic [31:0] op_elem, next_op_elem;
   logic [63:0] op_cap, next_op_cap;
   logic din_valid, next_din_valid;
   logic [7:0] din_byte, next_din_byte;
   logic [7:0] xcnt, next_xcnt;
   logic [7:0] xlast, next_xlast;
   // identifier store: no reset so it outlives i_nrst
   logic [7:0] id_len;
   logic [127:0] id_val;

   logic [7:0] op;
   logic [4:0] sa;
   logic [63:0] req_cap;
   logic [63:0] tgt_cap;
   logic [31:0] alloc;
   logic [7:0] total;
   logic is_rel, is_depop, is_rpt;

   always_comb
   begin
      op = cdb_byte(i_cdb, 0);
      sa = i_cdb[116:112];
      is_rel = (op == `RDI_OP_RELEASE10); // [R1] [R21]
      is_depop = (op == `RDI_OP_DEPOP) && (sa == `RDI_SA_DEPOP); // [R6] [R21]
      is_rpt = (op == `RDI_OP_RPTID) && (sa == `RDI_SA_RPTID); // [R14] [R21]
      req_cap = i_cdb[111:48];
      tgt_cap = (req_cap == 64'h0) ? i_cap_auto : req_cap; // [R7]
      alloc = i_cdb[79:48];
      total = `RDI_LEN_BYTES + id_len;
   end

   always_comb
   begin
      next_state = state;
      next_sense = sense;
      next_status = status;
      next_busy = busy;
      next_done = 1'b0;
      next_pass = 1'b0;
      next_resv_active = resv_active;
      next_resv_owner = resv_owner;
      next_capacity = capacity;
      next_fmt_corrupt = fmt_corrupt;
      next_op_start = 1'b0;
      next_op_elem = op_elem;
      next_op_cap = op_cap;
      next_din_valid = 1'b0;
      next_din_byte = din_byte;
      next_xcnt = xcnt;
      next_xlast = xlast;
      if (i_resv_take && !resv_active)
      begin
         next_resv_active = 1'b1;
         next_resv_owner = i_initiator;
      end
      // format completion clears corrupt only when the format was clean
      if (i_format_ok)
         next_fmt_corrupt = 1'b0; // [R10]
      unique case (state)
         RDI_IDLE:
         begin
            if (i_cdb_valid)
            begin
               next_done = 1'b1;
               next_status = `RDI_ST_GOOD;
               next_sense = `RDI_SNS_NONE;
               if (is_rel)
               begin
                  // reservation id byte and extent bit are never looked at
                  if (i_cdb[112 + `RDI_REL_TP_BIT]) // [R5]
                  begin
                     next_status = `RDI_ST_CHECK; // [R3]
                     next_sense = `RDI_SNS_INV_CDB;
                  end
                  else if (resv_active && resv_owner == i_initiator)
                     next_resv_active = 1'b0; // [R1] [R2]
               end
               else if (is_depop)
               begin
                  next_status = `RDI_ST_CHECK;
                  if (i_ucode_deferred)
                     next_sense = `RDI_SNS_UCODE_ACT; // [R12]
                  else if (!i_elem_known ||
                           i_elem_type != `RDI_ELEM_STORAGE)
                     next_sense = `RDI_SNS_INV_CDB; // [R9]
                  else if (!i_elem_depop_ok)
                     next_sense = `RDI_SNS_INV_CDB; // [R13]
                  else if (tgt_cap == 64'h0 || tgt_cap > capacity)
                     next_sense = `RDI_SNS_INV_CDB; // [R8]
                  else
                  begin
                     next_done = 1'b0;
                     next_status = status;
                     next_busy = 1'b1;
                     next_op_start = 1'b1; // [R6]
                     next_op_elem = i_cdb[47:16];
                     next_op_cap = tgt_cap;
                     next_state = RDI_WAIT;
                  end
               end
               else if (is_rpt)
               begin
                  if (i_cdb[95:80] != 16'h0)
                  begin
                     next_status = `RDI_ST_CHECK; // [R14]
                     next_sense = `RDI_SNS_INV_CDB;
                  end
                  else if (!i_nv_ready)
                  begin
                     next_status = `RDI_ST_CHECK; // [R20]
                     next_sense = `RDI_SNS_NV_NRDY;
                  end
                  else if (alloc != 32'h0)
                  begin
                     // transfer stops at allocation without error
                     next_xlast = (alloc < {24'h0, total}) ?
                                  alloc[7:0] - 8'h01 :
                                  total - 8'h01; // [R15]
                     next_xcnt = 8'h00;
                     next_done = 1'b0;
                     next_busy = 1'b1;
                     next_state = RDI_XFER;
                  end
               end
               else if (fmt_corrupt && i_medium_access)
               begin
                  next_status = `RDI_ST_CHECK; // [R11]
                  next_sense = `RDI_SNS_DEPOP_FAIL;
               end
               else
                  next_pass = 1'b1;
            end
         end
         RDI_WAIT:
         begin
            if (i_op_done)
            begin
               next_done = 1'b1;
               next_busy = 1'b0;
               next_state = RDI_IDLE;
               if (i_op_fail)
               begin
                  next_fmt_corrupt = 1'b1; // [R10]
                  next_status = `RDI_ST_CHECK;
                  next_sense = `RDI_SNS_DEPOP_FAIL;
               end
               else
               begin
                  next_capacity = op_cap; // [R7]
                  next_status = `RDI_ST_GOOD;
                  next_sense = `RDI_SNS_NONE;
               end
            end
         end
         RDI_XFER:
         begin
            // same stored identifier for any initiator or port
            next_din_valid = 1'b1; // [R19]
            next_din_byte = list_byte(xcnt, id_len, id_val); // [R16]
            next_xcnt = xcnt + 8'h01;
            if (xcnt == xlast)
            begin
               next_done = 1'b1;
               next_busy = 1'b0;
               next_state = RDI_IDLE;
            end
         end
         default:
            next_state = RDI_IDLE;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         state <= RDI_IDLE;
         sense <= `RDI_SNS_NONE;
         status <= `RDI_ST_GOOD;
         busy <= 1'b0;
         done <= 1'b0;
         pass <= 1'b0;
         resv_active <= 1'b0;
         resv_owner <= 8'h00;
         capacity <= `RDI_CAP_RESET;
         fmt_corrupt <= 1'b0;
         op_start <= 1'b0;
         op_elem <= 32'h0;
         op_cap <= 64'h0;
         din_valid <= 1'b0;
         din_byte <= 8'h00;
         xcnt <= 8'h00;
         xlast <= 8'h00;
      end
      else
      begin
         state <= next_state;
         sense <= next_sense;
         status <= next_status;
         busy <= next_busy;
         done <= next_done;
         pass <= next_pass;
         resv_active <= next_resv_active;
         resv_owner <= next_resv_owner;
         capacity <= next_capacity;
         fmt_corrupt <= next_fmt_corrupt;
         op_start <= next_op_start;
         op_elem <= next_op_elem;
         op_cap <= next_op_cap;
         din_valid <= next_din_valid;
         din_byte <= next_din_byte;
         xcnt <= next_xcnt;
         xlast <= next_xlast;
      end
   end

   // persistent store: only factory init or a good set touches it
   always_ff @(posedge i_clk)
   begin
      if (i_nv_init)
         id_len <= 8'h00; // [R17]
      else if (i_setid_valid)
      begin
         id_len <= i_setid_len; // [R17] [R18]
         id_val <= i_setid_data;
      end
   end

   assign o_busy = busy;
   assign o_done = done;
   assign o_pass = pass;
   assign o_status = status;
   assign o_sense_key = sense[19:16];
   assign o_asc = sense[15:8];
   assign o_ascq = sense[7:0];
   assign o_resv_active = resv_active;
   assign o_resv_owner = resv_owner;
   assign o_capacity = capacity;
   assign o_fmt_corrupt = fmt_corrupt;
   assign o_op_start = op_start;
   assign o_op_elem = op_elem;
   assign o_op_cap = op_cap;
   assign o_din_valid = din_valid;
   assign o_din_byte = din_byte;

   logic idle_cmd;
   assign idle_cmd = i_cdb_valid && state == RDI_IDLE;

   property p_rel_tp;
      @(posedge i_clk) disable iff (!i_nrst)
      idle_cmd && is_rel && i_cdb[116] |=> o_done &&
         o_status == `RDI_ST_CHECK && o_sense_key == `RDI_SK_ILLEGAL;
   endproperty
   a_rel_tp: assert property (p_rel_tp) // [R3]
      else $error("third-party release not rejected");

   property p_rel_other;
      @(posedge i_clk) disable iff (!i_nrst)
      idle_cmd && is_rel && !i_cdb[116] && resv_active &&
         resv_owner != i_initiator |=> o_resv_active &&
         $stable(o_resv_owner) && o_status == `RDI_ST_GOOD;
   endproperty
   a_rel_other: assert property (p_rel_other) // [R2]
      else $error("foreign reservation disturbed by release");

   property p_ucode;
      @(posedge i_clk) disable iff (!i_nrst)
      idle_cmd && is_depop && i_ucode_deferred |=> o_done &&
         o_sense_key == `RDI_SK_NOT_READY && !o_busy;
   endproperty
   a_ucode: assert property (p_ucode) // [R12]
      else $error("pending microcode did not block removal");

   property p_cap_keep;
      @(posedge i_clk) disable iff (!i_nrst)
      idle_cmd && is_depop && !i_ucode_deferred && i_elem_known &&
         i_elem_type == `RDI_ELEM_STORAGE && i_elem_depop_ok &&
         tgt_cap > capacity |=> $stable(o_capacity) ##1 $stable(o_capacity);
   endproperty
   a_cap_keep: assert property (p_cap_keep) // [R8]
      else $error("capacity changed on unsettable request");

   property p_corrupt;
      @(posedge i_clk) disable iff (!i_nrst)
      idle_cmd && fmt_corrupt && i_medium_access && !is_rel &&
         !is_depop && !is_rpt |=> o_done && !o_pass &&
         o_sense_key == `RDI_SK_MEDIUM;
   endproperty
   a_corrupt: assert property (p_corrupt) // [R11]
      else $error("medium access allowed while format corrupt");

   property p_lun;
      @(posedge i_clk) disable iff (!i_nrst)
      idle_cmd && is_rpt && i_cdb[95:80] != 16'h0 |=> o_done &&
         o_sense_key == `RDI_SK_ILLEGAL && !o_din_valid;
   endproperty
   a_lun: assert property (p_lun) // [R14]
      else $error("nonzero unit field accepted");

   property p_nv;
      @(posedge i_clk) disable iff (!i_nrst)
      idle_cmd && is_rpt && i_cdb[95:80] == 16'h0 && !i_nv_ready |=>
         o_done && o_sense_key == `RDI_SK_NOT_READY && !o_busy;
   endproperty
   a_nv: assert property (p_nv) // [R20]
      else $error("store not ready did not end report at once");

   property p_len_first;
      @(posedge i_clk) disable iff (!i_nrst)
      idle_cmd && is_rpt && i_cdb[95:80] == 16'h0 && i_nv_ready &&
         alloc >= 32'h4 && !i_setid_valid && !i_nv_init ##1 1'b1 |=>
         o_din_valid && o_din_byte == 8'h00 ##3 o_din_byte == id_len;
   endproperty
   a_len_first: assert property (p_len_first) // [R16]
      else $error("length field not leading the parameter list");

   property p_len_stable;
      @(posedge i_clk)
      !i_setid_valid && !i_nv_init |=> $stable(id_len);
   endproperty
   a_len_stable: assert property (p_len_stable) // [R17]
      else $error("identifier length changed without a set");

   property p_short;
      @(posedge i_clk) disable iff (!i_nrst)
      idle_cmd && is_rpt && i_cdb[95:80] == 16'h0 && i_nv_ready &&
         alloc == 32'h2 |=> ##2 o_done && o_status == `RDI_ST_GOOD;
   endproperty
   a_short: assert property (p_short) // [R15]
      else $error("short allocation not ended good after two bytes");

endmodule // rdi_cmd_decoder
`default_nettype wire

// file: verification/rdi_media_model.sv
// behavioural element-removal engine answering the decoder's start pulses
`timescale 1ns/1ps
`default_nettype none
module rdi_media_model
(
   input wire logic i_clk,
   input wire logic i_op_start,
   input wire logic [7:0] i_delay,
   input wire logic i_fail,
   output logic o_op_done,
   output logic o_op_fail
);
   logic [7:0] cnt;
   logic run;
   initial
   begin
      run = 1'b0;
      cnt = 8'h00;
      o_op_done = 1'b0;
      o_op_fail = 1'b0;
   end
   always @(posedge i_clk)
   begin
      o_op_done <= 1'b0;
      // flag means nothing outside the answer cycle, so show the inverse
      o_op_fail <= ~i_fail;
      if (i_op_start)
      begin
         run <= 1'b1;
         cnt <= i_delay;
      end
      else if (run && cnt == 8'h00)
      begin
         run <= 1'b0;
         o_op_done <= 1'b1;
         o_op_fail <= i_fail;
      end
      else if (run)
         cnt <= cnt - 8'h01;
   end
endmodule // rdi_media_model
`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench for the release / removal / identifier decoder
`timescale 1ns/1ps
`default_nettype none
`include "rdi_cfg.svh"
module tb_top;
   logic i_clk, i_nrst, i_cdb_valid, i_medium_access, i_resv_take;
   logic i_ucode_deferred, i_elem_known, i_elem_depop_ok, i_op_done;
   logic i_op_fail, i_format_ok, i_nv_ready, i_nv_init, i_setid_valid;
   logic [127:0] i_cdb, i_setid_data, idv;
   logic [7:0] i_initiator, i_elem_type, i_setid_len, o_status, o_asc;
   logic [7:0] o_ascq, o_resv_owner, o_din_byte, dly, idl;
   logic [63:0] i_cap_auto, o_capacity, o_op_cap;
   logic [31:0] o_op_elem;
   logic [3:0] o_sense_key;
   logic o_busy, o_done, o_pass, o_resv_active, o_fmt_corrupt;
   logic o_op_start, o_din_valid, fail, psd, sst;
   logic [7:0] rx [$];
   int failures, check_count, cycles, lat;
   rdi_cmd_decoder rdi_cmd_decoder_i (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_cdb_valid(i_cdb_valid), .i_cdb(i_cdb), .i_initiator(i_initiator),
      .i_medium_access(i_medium_access), .i_resv_take(i_resv_take),
      .i_ucode_deferred(i_ucode_deferred), .i_elem_type(i_elem_type),
      .i_elem_known(i_elem_known), .i_elem_depop_ok(i_elem_depop_ok),
      .i_cap_auto(i_cap_auto), .i_op_done(i_op_done),
      .i_op_fail(i_op_fail), .i_format_ok(i_format_ok),
      .i_nv_ready(i_nv_ready), .i_nv_init(i_nv_init),
      .i_setid_valid(i_setid_valid), .i_setid_len(i_setid_len),
      .i_setid_data(i_setid_data), .o_busy(o_busy), .o_done(o_done),
      .o_pass(o_pass), .o_status(o_status), .o_sense_key(o_sense_key),
      .o_asc(o_asc), .o_ascq(o_ascq), .o_resv_active(o_resv_active),
      .o_resv_owner(o_resv_owner), .o_capacity(o_capacity),
      .o_fmt_corrupt(o_fmt_corrupt), .o_op_start(o_op_start),
      .o_op_elem(o_op_elem), .o_op_cap(o_op_cap),
      .o_din_valid(o_din_valid), .o_din_byte(o_din_byte));
   rdi_media_model rdi_media_model_i (.i_clk(i_clk),
      .i_op_start(o_op_start), .i_delay(dly), .i_fail(fail),
      .o_op_done(i_op_done), .o_op_fail(i_op_fail));
   initial i_clk = 1'b0;
   always #2 i_clk = ~i_clk;
   task automatic conclude;
   begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
   endtask
   // whole run needs well under a thousand cycles
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         $display("timeout at %0t", $time);
         conclude();
      end
   end
   task automatic tick;
   begin
      @(posedge i_clk);
      #1;
   end
   endtask
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
   begin
      check_count++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   end
   endtask
   task automatic st(input logic [27:0] e);
      chk({36'h0, o_status, o_sense_key, o_asc, o_ascq}, {36'h0, e});
   endtask
   task automatic rv(input logic a, input logic [7:0] o);
      chk({55'h0, o_resv_active, a ? o_resv_owner : 8'h00}, {55'h0, a, o});
   endtask
   task automatic cmd(input logic [127:0] c, input logic [7:0] ini,
                      input logic ma);
   begin
      lat = 0;
      sst = 1'b0;
      rx.delete();
      tick();
      i_cdb = c;
      i_initiator = ini;
      i_medium_access = ma;
      i_cdb_valid = 1'b1;
      tick();
      i_cdb_valid = 1'b0;
      while (o_done !== 1'b1 && o_pass !== 1'b1 && lat < 300)
      begin
         if (o_op_start === 1'b1)
            sst = 1'b1;
         if (o_din_valid === 1'b1)
            rx.push_back(o_din_byte);
         tick();
         lat++;
      end
      if (o_din_valid === 1'b1)
         rx.push_back(o_din_byte);
      psd = (o_pass === 1'b1);
      if (lat == 300)
         chk(64'h0, 64'h1);
   end
   endtask
   task automatic rep(input logic [31:0] alloc, input logic [7:0] ini);
      int n;
      logic [7:0] e;
   begin
      cmd({8'ha3, 8'h05, 16'h0, 16'h0, alloc, 48'h0}, ini, 1'b0);
      st({`RDI_ST_GOOD, `RDI_SNS_NONE});
      n = (alloc < 32'd4 + idl) ? int'(alloc) : 4 + int'(idl);
      chk(64'(rx.size()), 64'(n));
      for (int k = 0; k < n && k < rx.size(); k++)
      begin
         e = (k < 3) ? 8'h00 : (k == 3) ? idl : idv[127-8*(k-4) -: 8];
         chk({56'h0, rx[k]}, {56'h0, e});
      end
   end
   endtask
   task automatic dep(input logic [63:0] cap, input logic [27:0] e);
   begin
      cmd({8'h9e, 8'h18, cap, 32'h0000_0007, 16'h0}, 8'h01, 1'b0);
      st(e);
      // only an accepted removal may start the engine; busy ends with done
      chk({62'h0, sst, o_busy}, {62'h0, (e[27:20] == `RDI_ST_GOOD ||
          e[19:0] == `RDI_SNS_DEPOP_FAIL), 1'b0});
   end
   endtask
   initial
   begin
      {i_cdb_valid, i_medium_access, i_resv_take, i_ucode_deferred} = 4'h0;
      {i_format_ok, i_nv_ready, i_nv_init, i_setid_valid, fail} = 5'h00;
      {i_elem_known, i_elem_depop_ok} = 2'b11;
      i_nrst = 1'b0;
      i_cdb = 128'h0;
      i_initiator = 8'h00;
      i_elem_type = `RDI_ELEM_STORAGE;
      i_cap_auto = 64'h0000_0000_0040_0000;
      i_setid_len = 8'h00;
      i_setid_data = 128'h0;
      dly = 8'h01;
      idl = 8'h00;
      idv = 128'h0;
      repeat (5) @(posedge i_clk);
      #1;
      i_nrst = 1'b1;
      chk(o_capacity, `RDI_CAP_RESET);
      st({`RDI_ST_GOOD, `RDI_SNS_NONE});
      $display("test reset done");
      i_initiator = 8'h01;
      i_resv_take = 1'b1;
      tick();
      i_resv_take = 1'b0;
      rv(1'b1, 8'h01);
      cmd({8'h57, 8'h00, 8'h3c, 104'h0}, 8'h02, 1'b0);
      st({`RDI_ST_GOOD, `RDI_SNS_NONE});
      rv(1'b1, 8'h01);
      cmd({8'h57, 8'h10, 8'h00, 104'h0}, 8'h01, 1'b0);
      st({`RDI_ST_CHECK, `RDI_SNS_INV_CDB});
      rv(1'b1, 8'h01);
      cmd({8'h57, 8'h00, 8'ha5, 104'h0}, 8'h01, 1'b0);
      st({`RDI_ST_GOOD, `RDI_SNS_NONE});
      rv(1'b0, 8'h00);
      $display("test release done");
      i_ucode_deferred = 1'b1;
      dep(64'h80_0000, {`RDI_ST_CHECK, `RDI_SNS_UCODE_ACT});
      i_ucode_deferred = 1'b0;
      i_elem_type = 8'h02;
      dep(64'h80_0000, {`RDI_ST_CHECK, `RDI_SNS_INV_CDB});
      i_elem_type = `RDI_ELEM_STORAGE;
      i_elem_known = 1'b0;
      dep(64'h80_0000, {`RDI_ST_CHECK, `RDI_SNS_INV_CDB});
      i_elem_known = 1'b1;
      i_elem_depop_ok = 1'b0;
      dep(64'h80_0000, {`RDI_ST_CHECK, `RDI_SNS_INV_CDB});
      i_elem_depop_ok = 1'b1;
      dep(64'h200_0000, {`RDI_ST_CHECK, `RDI_SNS_INV_CDB});
      chk(o_capacity, `RDI_CAP_RESET);
      dep(64'h80_0000, {`RDI_ST_GOOD, `RDI_SNS_NONE});
      chk(o_capacity, 64'h80_0000);
      chk({32'h0, o_op_elem}, 64'h7);
      chk(o_op_cap, 64'h80_0000);
      dly = 8'd20;
      dep(64'h0, {`RDI_ST_GOOD, `RDI_SNS_NONE});
      chk(o_capacity, i_cap_auto);
      chk(o_op_cap, i_cap_auto);
      fail = 1'b1;
      dep(64'h10_0000, {`RDI_ST_CHECK, `RDI_SNS_DEPOP_FAIL});
      fail = 1'b0;
      chk({63'h0, o_fmt_corrupt}, 64'h1);
      cmd({8'h28, 120'h0}, 8'h01, 1'b1);
      st({`RDI_ST_CHECK, `RDI_SNS_DEPOP_FAIL});
      cmd({8'h12, 120'h0}, 8'h01, 1'b0);
      chk({63'h0, psd}, 64'h1);
      cmd({8'h9e, 8'h10, 112'h0}, 8'h01, 1'b0);
      chk({63'h0, psd}, 64'h1);
      i_format_ok = 1'b1;
      tick();
      i_format_ok = 1'b0;
      chk({63'h0, o_fmt_corrupt}, 64'h0);
      cmd({8'h28, 120'h0}, 8'h01, 1'b1);
      chk({63'h0, psd}, 64'h1);
      $display("test removal done");
      cmd({8'ha3, 8'h05, 32'h0, 32'h8, 48'h0}, 8'h01, 1'b0);
      st({`RDI_ST_CHECK, `RDI_SNS_NV_NRDY});
      chk(64'(lat), 64'h0);
      i_nv_ready = 1'b1;
      i_nv_init = 1'b1;
      tick();
      i_nv_init = 1'b0;
      rep(32'h8, 8'h01);
      i_setid_len = 8'h02;
      i_setid_data = {8'hc3, 8'h5a, 112'h1122};
      i_setid_valid = 1'b1;
      tick();
      i_setid_valid = 1'b0;
      idl = 8'h02;
      idv = {8'hc3, 8'h5a, 112'h1122};
      rep(32'h5, 8'h01);
      rep(32'h2, 8'h01);
      rep(32'h0, 8'h01);
      rep(32'h40, 8'h01);
      rep(32'd20, 8'h09);
      cmd({8'ha3, 8'h05, 16'h0, 16'h1, 32'h20, 48'h0}, 8'h01, 1'b0);
      st({`RDI_ST_CHECK, `RDI_SNS_INV_CDB});
      $display("test identifier done");
      i_format_ok = 1'b1;
      tick();
      i_format_ok = 1'b0;
      i_nrst = 1'b0;
      tick();
      tick();
      i_nrst = 1'b1;
      chk(o_capacity, `RDI_CAP_RESET);
      rep(32'd20, 8'h01);
      $display("test persistence done");
      conclude();
   end
endmodule // tb_top
`default_nettype wire
